/* bench/uecs_asserts.sv */
// checker: concurrent assertions on the endpoint control/status top
`timescale 1ns/100ps
`default_nettype none
module uecs_asserts
    import uecs_pkg::*;
(
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_rstn,
    // inputs watched
    input wire uecs_mem_s  i_mem,
    input wire uecs_evt_s  i_evt,
    // outputs watched
    input wire logic [7:0] o_rdata,
    input wire logic       o_hit,
    input wire logic [2:0] o_halt,
    input wire logic [2:0] o_pipe_in,
    input wire logic [2:0] o_ep_enable,
    input wire logic       o_force_data0,
    input wire logic [7:0] o_device_address,
    input wire logic       o_nak_irq,
    input wire logic       o_fifo_request,
    input wire logic       o_fifo_write,
    input wire logic [1:0] o_fifo_select,
    input wire logic [2:0] o_fifo_onehot
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    ////////////////////////////////////////////////////////////////////////////////////////
    logic [7:0] wd_ff;
    logic       mode_ff;
    logic       mask_ff;
    logic       mapped;
    function automatic logic wr_at(input uecs_mem_s m, input logic [7:0] a);
        return m.wr && m.addr == a;
    endfunction : wr_at
    assign mapped = i_mem.addr inside {8'h41, 8'h42, 8'h43, 8'h45, 8'h46, 8'h47};
    always_ff @(posedge i_clk) begin
        wd_ff <= i_mem.wdata;
    end
    // shadow of mode and mask; address done beats a same-cycle mode write
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mode_ff <= 1'b0;
            mask_ff <= 1'b0;
        end else begin
            if (wr_at(i_mem, ADDR_TOKEN_ERROR_STATUS)) begin
                mode_ff <= i_mem.wdata[0];
                mask_ff <= i_mem.wdata[7];
            end
            if (i_evt.in_read_done && mode_ff) begin
                mode_ff <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    sequence s_dir_low;
        wr_at(i_mem, ADDR_PIPE_DIRECTION_TOGGLE) && !i_mem.wdata[0]
        ##1 !wr_at(i_mem, ADDR_PIPE_DIRECTION_TOGGLE);
    endsequence
    sequence s_dir_high;
        wr_at(i_mem, ADDR_PIPE_DIRECTION_TOGGLE) && i_mem.wdata[0]
        ##1 !wr_at(i_mem, ADDR_PIPE_DIRECTION_TOGGLE);
    endsequence
    a_read_mapped: assert property (i_mem.rd && mapped |=> o_hit)
        else $error("mapped read without hit");
    a_read_unmapped: assert property (i_mem.rd && !mapped |=> !o_hit && o_rdata == 8'h00)
        else $error("unmapped read answered");
    a_toggle_force: assert property (s_dir_low |=> o_force_data0)
        else $error("toggle reset not forced");
    a_toggle_release: assert property (s_dir_high |=> !o_force_data0)
        else $error("toggle reset not released");
    a_pipe_dir: assert property (wr_at(i_mem, ADDR_PIPE_DIRECTION_TOGGLE)
        |=> o_pipe_in == {wd_ff[2:1], 1'b0})
        else $error("pipe direction wrong");
    a_halt_write: assert property (wr_at(i_mem, ADDR_ENDPOINT_HALT_FLAGS)
        |=> o_halt == wd_ff[2:0])
        else $error("halt flags wrong");
    a_enable_write: assert property (wr_at(i_mem, ADDR_ENDPOINT_ENABLE)
        |=> o_ep_enable == {wd_ff[2:1], 1'b1})
        else $error("endpoint enable wrong");
    a_addr_direct: assert property (wr_at(i_mem, ADDR_DEVICE_ADDRESS) && !mode_ff
        |=> o_device_address == {1'b0, wd_ff[7:1]})
        else $error("address not adopted");
    a_addr_deferred: assert property (wr_at(i_mem, ADDR_DEVICE_ADDRESS) && mode_ff
        && !i_evt.in_read_done |=> $stable(o_device_address))
        else $error("address adopted early");
    a_nak_irq: assert property (i_evt.nak_sent && !mask_ff |=> o_nak_irq)
        else $error("nak interrupt missing");
    a_nak_masked: assert property (!i_evt.nak_sent || mask_ff |=> !o_nak_irq)
        else $error("nak interrupt not masked");
    a_sel_decode: assert property (o_fifo_select != 2'h3
        |-> o_fifo_onehot == (3'h1 << o_fifo_select))
        else $error("fifo select decode wrong");
    a_fifo_cmd: assert property (wr_at(i_mem, ADDR_FIFO_COMMAND_STATUS)
        |=> o_fifo_select == wd_ff[4:3] && o_fifo_request == wd_ff[0]
        && o_fifo_write == wd_ff[1])
        else $error("fifo command fields wrong");
endmodule : uecs_asserts
bind uecs_top uecs_asserts u_asserts (.i_clk, .i_rstn, .i_mem, .i_evt, .o_rdata, .o_hit,
    .o_halt, .o_pipe_in, .o_ep_enable, .o_force_data0, .o_device_address, .o_nak_irq,
    .o_fifo_request, .o_fifo_write, .o_fifo_select, .o_fifo_onehot);
`default_nettype wire

/* bench/uecs_engine_model.sv */
// engine-side model: turns bench event requests into one-cycle engine pulses
`timescale 1ns/100ps
`default_nettype none
module uecs_engine_model
    import uecs_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    // event requests, one bit per event field
    input  wire logic [7:0] i_req,
    // pulses to the block
    output uecs_evt_s       o_evt
);
    ////////////////////////////////////////////////////////////////////////////////////////
    // registered so a pulse never shares an edge with the request that caused it
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_evt <= '0;
        end else begin
            o_evt <= uecs_evt_s'(i_req);
        end
    end
endmodule : uecs_engine_model
`default_nettype wire

/* bench/usb_endpoint_control_status_bench.sv */
// bench: register and event scenarios for the endpoint control/status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module usb_endpoint_control_status_bench;
    import uecs_pkg::*;
    localparam logic [7:0] PD = ADDR_PIPE_DIRECTION_TOGGLE;
    localparam logic [7:0] TS = ADDR_TOKEN_ERROR_STATUS;
    localparam logic [7:0] FC = ADDR_FIFO_COMMAND_STATUS;
    logic       i_clk = 1'b0;
    logic       i_rstn = 1'b0;
    uecs_mem_s  mem = '0;
    uecs_lvl_s  lvl = 3'b010;
    uecs_evt_s  evt;
    logic [7:0] req = 8'h00;
    logic [7:0] o_rdata, o_device_address, w, exp_v, expq[$];
    logic [2:0] o_halt, o_pipe_in, o_ep_enable, o_fifo_onehot;
    logic [1:0] o_fifo_select;
    logic       o_hit, o_force_data0, o_remote_wakeup, o_nak_irq;
    logic       o_fifo_request, o_fifo_write, o_fifo_clear;
    logic [31:0] st = 32'h910A9DD3;
    logic [7:0] ctl[3] = '{ADDR_PIPE_DIRECTION_TOGGLE, ADDR_ENDPOINT_HALT_FLAGS,
                           ADDR_ENDPOINT_ENABLE};
    int         n_fail = 0;
    int         samples_checked = 0;
    always #10 i_clk = ~i_clk;
    uecs_engine_model u_eng (.i_clk, .i_rstn, .i_req(req), .o_evt(evt));
    uecs_top dut (.i_clk, .i_rstn, .i_mem(mem), .o_rdata, .o_hit, .i_evt(evt), .i_lvl(lvl),
        .o_halt, .o_pipe_in, .o_ep_enable, .o_force_data0, .o_device_address,
        .o_remote_wakeup, .o_nak_irq, .o_fifo_request, .o_fifo_write, .o_fifo_clear,
        .o_fifo_select, .o_fifo_onehot);
    ////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic acc(input logic wv, input logic rv, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        mem <= '{wv, rv, a, d};
        @(posedge i_clk);
        mem <= '0;
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask : wr
    // expectation queued first; the monitor pairs it with the next hit
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        acc(1'b0, 1'b1, a, 8'h00);
    endtask : rd
    task automatic fire(input logic [7:0] m);
        @(posedge i_clk);
        req <= m;
        @(posedge i_clk);
        req <= 8'h00;
        @(posedge i_clk);
        @(negedge i_clk);
    endtask : fire
    task automatic give_verdict;
        if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////////////////
    always @(posedge i_clk) begin
        if (o_hit === 1'b1) begin
            exp_v = expq.size() > 0 ? expq.pop_front() : 8'hXX;
            `CHK("rdata", exp_v, o_rdata)
        end
    end
    // about 130 cycles expected; hang cut off at 5000, well beyond that
    initial begin
        repeat (5000) @(posedge i_clk);
        n_fail++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(negedge i_clk);
        `CHK("force", 1'b1, o_force_data0)
        `CHK("pipe_in", 3'h6, o_pipe_in)
        `CHK("halt", 3'h7, o_halt)
        rd(PD, 8'h06);
        rd(ctl[1], 8'h07);
        rd(ctl[2], 8'h07);
        rd(TS, 8'h40);
        acc(1'b0, 1'b1, 8'h44, 8'h00);
        @(negedge i_clk);
        `CHK("hit", 1'b0, o_hit)
        foreach (ctl[i]) begin
            wr(ctl[i], 8'hFF);
            rd(ctl[i], 8'h07);
        end
        wr(PD, 8'h00);
        repeat (10) @(posedge i_clk);
        @(negedge i_clk);
        `CHK("force", 1'b1, o_force_data0)
        `CHK("pipe_in", 3'h0, o_pipe_in)
        wr(PD, 8'h07);
        @(posedge i_clk);
        @(negedge i_clk);
        `CHK("force", 1'b0, o_force_data0)
        for (int i = 0; i < 3; i++) begin
            st = lfsr(st);
            wr(ctl[1], st[7:0]);
            @(negedge i_clk);
            `CHK("halt", st[2:0], o_halt)
            wr(ctl[2], st[7:0]);
            @(negedge i_clk);
            `CHK("ep_en", {st[2:1], 1'b1}, o_ep_enable)
        end
        wr(ADDR_DEVICE_ADDRESS, 8'hA5);
        @(negedge i_clk);
        `CHK("addr", 8'h52, o_device_address)
        `CHK("wakeup", 1'b1, o_remote_wakeup)
        wr(TS, 8'h01);
        wr(ADDR_DEVICE_ADDRESS, 8'h3C);
        @(negedge i_clk);
        `CHK("addr", 8'h52, o_device_address)
        `CHK("wakeup", 1'b0, o_remote_wakeup)
        fire(8'h80);
        `CHK("addr", 8'h1E, o_device_address)
        rd(TS, 8'h40);
        fire(8'h78);
        `CHK("nak_irq", 1'b1, o_nak_irq)
        rd(TS, 8'h76);
        fire(8'h04);
        rd(TS, 8'h62);
        wr(TS, 8'h80);
        rd(TS, 8'hC0);
        fire(8'h08);
        `CHK("nak_irq", 1'b0, o_nak_irq)
        rd(TS, 8'hD0);
        @(posedge i_clk);
        lvl <= 3'b100;
        rd(TS, 8'h88);
        lvl <= 3'b010;
        for (int s = 0; s < 3; s++) begin
            w = {3'h0, s[1:0], 1'b0, s[0], 1'b0};
            wr(FC, w);
            wr(FC, w | 8'h01);
            @(negedge i_clk);
            `CHK("sel", s[1:0], o_fifo_select)
            `CHK("onehot", 3'h1 << s, o_fifo_onehot)
            `CHK("write", s[0], o_fifo_write)
            `CHK("request", 1'b1, o_fifo_request)
            w = w ^ 8'h02;
            wr(FC, w | 8'h01);
            wr(FC, w);
        end
        lvl <= 3'b011;
        rd(FC, 8'h52);
        fire(8'h03);
        rd(FC, 8'hF2);
        acc(1'b0, 1'b1, ADDR_FIFO0, 8'h00);
        rd(FC, 8'h72);
        wr(FC, 8'h04);
        @(negedge i_clk);
        `CHK("clear", 1'b1, o_fifo_clear)
        rd(FC, 8'h44);
        repeat (3) @(posedge i_clk);
        `CHK("pending", 0, expq.size())
        give_verdict();
    end
endmodule : usb_endpoint_control_status_bench
`default_nettype wire

/* src/uecs_pkg.sv */
// package: register map, field layout, reset values and carriers for endpoint control/status
package uecs_pkg;

    // register addresses in data memory
    localparam logic [7:0] ADDR_PIPE_DIRECTION_TOGGLE = 8'h41;
    localparam logic [7:0] ADDR_DEVICE_ADDRESS        = 8'h42;
    localparam logic [7:0] ADDR_ENDPOINT_HALT_FLAGS   = 8'h43;
    localparam logic [7:0] ADDR_TOKEN_ERROR_STATUS    = 8'h45;
    localparam logic [7:0] ADDR_FIFO_COMMAND_STATUS   = 8'h46;
    localparam logic [7:0] ADDR_ENDPOINT_ENABLE       = 8'h47;
    localparam logic [7:0] ADDR_FIFO0                 = 8'h48;
    localparam logic [7:0] ADDR_FIFO1                 = 8'h49;
    localparam logic [7:0] ADDR_FIFO2                 = 8'h4A;

    // reset values
    localparam logic [2:0] RST_PIPE_DIRECTION = 3'h6;
    localparam logic [2:0] RST_HALT_FLAGS     = 3'h7;
    localparam logic [2:0] RST_ENDPOINT_EN    = 3'h7;
    localparam logic [7:0] RST_DEVICE_ADDRESS = 8'h00;

    // pipe direction / toggle field
    localparam int PDT_TOGGLE_RESET_BIT = 0;

    // token status fields
    localparam int TES_ADDR_UPDATE_MODE = 0;
    localparam int TES_EP0_FIFO_ERROR   = 1;
    localparam int TES_OUT_RECEIVED     = 2;
    localparam int TES_IN_TOKEN         = 3;
    localparam int TES_NAK_SENT         = 4;
    localparam int TES_CHECKSUM_ERROR   = 5;
    localparam int TES_END_OF_TRANSFER  = 6;
    localparam int TES_NAK_INT_MASK     = 7;

    // fifo command/status fields
    localparam int FCS_REQUEST          = 0;
    localparam int FCS_DIRECTION        = 1;
    localparam int FCS_CLEAR            = 2;
    localparam int FCS_PIPE_SELECT_LOW  = 3;
    localparam int FCS_PIPE_SELECT_HIGH = 4;
    localparam int FCS_SETUP_COMMAND    = 5;
    localparam int FCS_READY            = 6;
    localparam int FCS_ZERO_LENGTH      = 7;

    // pipe selection codes
    localparam logic [1:0] SEL_FIFO0 = 2'h0;
    localparam logic [1:0] SEL_FIFO1 = 2'h1;
    localparam logic [1:0] SEL_FIFO2 = 2'h2;

    // engine events, each a one-cycle pulse
    typedef struct packed {
        logic in_read_done;
        logic ep0_fifo_error;
        logic out_received;
        logic checksum_error;
        logic nak_sent;
        logic setup_token;
        logic zero_length;
        logic setup_command;
    } uecs_evt_s;

    // engine levels
    typedef struct packed {
        logic in_token;
        logic end_of_transfer_flag;
        logic fifo_ready;
    } uecs_lvl_s;

    // firmware data memory access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } uecs_mem_s;

endpackage : uecs_pkg

/* src/uecs_sticky.sv */
// sticky flag: hardware set beats clear, software clear
`timescale 1ns/100ps
`default_nettype none
module uecs_sticky
    import uecs_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // controls
    input  wire logic i_set,
    input  wire logic i_clr,
    // state
    output logic      o_q
);

    logic q_ff;

    // set wins so an event landing on a clear is kept
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            q_ff <= 1'b0;
        end else if (i_set) begin
            q_ff <= 1'b1;
        end else if (i_clr) begin
            q_ff <= 1'b0;
        end
    end

    assign o_q = q_ff;

endmodule : uecs_sticky
`default_nettype wire

/* src/uecs_toggle_reset.sv */
// toggle-reset detector: low level on the toggle bit clears non-zero endpoint toggles
`timescale 1ns/100ps
`default_nettype none
module uecs_toggle_reset
    import uecs_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rstn,
    // toggle bit level
    input  wire logic i_toggle_bit,
    // strobe to the engine
    output logic      o_force_data0
);

    logic force_ff;

    // level driven: firmware holds it low long enough, so no counting here
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            // toggle bit resets low, so the force stands from reset on
            force_ff <= 1'b1;
        end else begin
            force_ff <= ~i_toggle_bit;
        end
    end

    assign o_force_data0 = force_ff;

endmodule : uecs_toggle_reset
`default_nettype wire

/* src/uecs_top.sv */
// top: firmware-visible endpoint control and status registers of the serial interface engine
// Functional notes
// RULE_01: firmware sets an endpoint's halt bit when it misbehaves; bits 0..2 are pipes 0..2
// RULE_02: direction bits 1 and 2 select IN when one, OUT when zero; default IN
// RULE_03: low level on toggle bit 0 forces non-zero endpoint toggles to DATA0
// RULE_04: firmware holds the toggle bit low at least ten instruction cycles
// RULE_05: enable bits enable endpoints 1 and 2 when one; endpoint zero unaffected
// RULE_06: three control registers use bits 2..0; reset to 06, 07, 07
// RULE_07: mode one: address loads after successful IN read, then mode bit self-clears
// RULE_08: mode zero: address written is adopted immediately
// RULE_09: engine sets endpoint-zero fifo error; only firmware clears it
// RULE_10: OUT-received set on non-empty OUT; cleared by firmware or next SETUP
// RULE_11: read-only IN flag shows current token is IN
// RULE_12: read-only NAK flag shows a NAK was answered to IN or OUT
// RULE_13: engine sets checksum error on CRC failure; firmware clears it
// RULE_14: end-of-transfer flag reads engine state, normally one
// RULE_15: NAK mask bit one suppresses the NAK interrupt; resets to zero
// RULE_16: token status layout: mask, eot, crc, nak, in, out, fifo0 err, mode
// RULE_17: fifo command layout: zlen, ready, setup, sel hi, sel lo, clear, dir, req
// RULE_18: pipe select 00, 01, 10 choose fifo zero, one, two
// RULE_19: firmware raises request after other fields, drops it when done
// RULE_20: direction one means write; firmware sequences it around request end
// RULE_21: zero-length flag set on empty packet; cleared by fifo read or SETUP
// RULE_22: reserved bits 7..3 of the three control registers ignore writes, read zero
`timescale 1ns/100ps
`default_nettype none
module uecs_top
    import uecs_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    // firmware data memory port
    input  wire uecs_mem_s  i_mem,
    output logic [7:0]      o_rdata,
    output logic            o_hit,
    // engine events and levels
    input  wire uecs_evt_s  i_evt,
    input  wire uecs_lvl_s  i_lvl,
    // controls to the engine
    output logic [2:0]      o_halt,
    output logic [2:0]      o_pipe_in,
    output logic [2:0]      o_ep_enable,
    output logic            o_force_data0,
    output logic [7:0]      o_device_address,
    output logic            o_remote_wakeup,
    output logic            o_nak_irq,
    // fifo command to the engine
    output logic            o_fifo_request,
    output logic            o_fifo_write,
    output logic            o_fifo_clear,
    output logic [1:0]      o_fifo_select,
    output logic [2:0]      o_fifo_onehot
);

    ////////////////////////////////////////////////////////////////////////////
    // decode
    logic wr_pdt;
    logic wr_adr;
    logic wr_hlt;
    logic wr_tes;
    logic wr_fcs;
    logic wr_een;
    logic fifo_rd;

    assign wr_pdt  = i_mem.wr && (i_mem.addr == ADDR_PIPE_DIRECTION_TOGGLE);
    assign wr_adr  = i_mem.wr && (i_mem.addr == ADDR_DEVICE_ADDRESS);
    assign wr_hlt  = i_mem.wr && (i_mem.addr == ADDR_ENDPOINT_HALT_FLAGS);
    assign wr_tes  = i_mem.wr && (i_mem.addr == ADDR_TOKEN_ERROR_STATUS);
    assign wr_fcs  = i_mem.wr && (i_mem.addr == ADDR_FIFO_COMMAND_STATUS);
    assign wr_een  = i_mem.wr && (i_mem.addr == ADDR_ENDPOINT_ENABLE);
    assign fifo_rd = i_mem.rd && ((i_mem.addr == ADDR_FIFO0) || (i_mem.addr == ADDR_FIFO1)
                                  || (i_mem.addr == ADDR_FIFO2));

    ////////////////////////////////////////////////////////////////////////////
    // control registers, three bits each
    logic [2:0] pdt_ff;
    logic [2:0] hlt_ff;
    logic [2:0] een_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pdt_ff <= RST_PIPE_DIRECTION;                     // see RULE_06
        end else if (wr_pdt) begin
            pdt_ff <= i_mem.wdata[2:0];                       // see RULE_22
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            hlt_ff <= RST_HALT_FLAGS;                         // see RULE_06
        end else if (wr_hlt) begin
            hlt_ff <= i_mem.wdata[2:0];                       // see RULE_01
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            een_ff <= RST_ENDPOINT_EN;                        // see RULE_06
        end else if (wr_een) begin
            een_ff <= i_mem.wdata[2:0];
        end
    end

    assign o_halt      = hlt_ff;
    // endpoint zero is a control pipe: always enabled, direction per stage
    assign o_pipe_in   = {pdt_ff[2:1], 1'b0};                 // see RULE_02
    assign o_ep_enable = {een_ff[2:1], 1'b1};                 // see RULE_05

    uecs_toggle_reset u_toggle (
        .i_clk         (i_clk),
        .i_rstn        (i_rstn),
        .i_toggle_bit  (pdt_ff[PDT_TOGGLE_RESET_BIT]),
        .o_force_data0 (o_force_data0)                        // see RULE_03
    );

    ////////////////////////////////////////////////////////////////////////////
    // device address
    logic [7:0] adr_reg_ff;
    logic [7:0] dev_adr_ff;
    logic       mode_ff;
    logic       nak_mask_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            adr_reg_ff <= RST_DEVICE_ADDRESS;
        end else if (wr_adr) begin
            adr_reg_ff <= i_mem.wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            dev_adr_ff <= RST_DEVICE_ADDRESS;
        end else if (wr_adr && !mode_ff) begin
            dev_adr_ff <= i_mem.wdata;                        // see RULE_08
        end else if (mode_ff && i_evt.in_read_done) begin
            dev_adr_ff <= adr_reg_ff;                         // see RULE_07
        end
    end

    // hardware clear on update wins over a simultaneous firmware write
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mode_ff <= 1'b0;
        end else if (mode_ff && i_evt.in_read_done) begin
            mode_ff <= 1'b0;                                  // see RULE_07
        end else if (wr_tes) begin
            mode_ff <= i_mem.wdata[TES_ADDR_UPDATE_MODE];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            nak_mask_ff <= 1'b0;                              // see RULE_15
        end else if (wr_tes) begin
            nak_mask_ff <= i_mem.wdata[TES_NAK_INT_MASK];
        end
    end

    assign o_device_address = {1'b0, dev_adr_ff[7:1]};
    assign o_remote_wakeup  = adr_reg_ff[0];

    ////////////////////////////////////////////////////////////////////////////
    // sticky status flags; firmware clears all but nak and zero-length by writing zero
    logic ep0_err_q;
    logic out_q;
    logic crc_q;
    logic nak_q;
    logic zlen_q;
    logic setup_q;

    uecs_sticky u_ep0_err (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_set  (i_evt.ep0_fifo_error),
        .i_clr  (wr_tes && !i_mem.wdata[TES_EP0_FIFO_ERROR]), // see RULE_09
        .o_q    (ep0_err_q)
    );

    uecs_sticky u_out (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_set  (i_evt.out_received),
        .i_clr  ((wr_tes && !i_mem.wdata[TES_OUT_RECEIVED]) || i_evt.setup_token), // see RULE_10
        .o_q    (out_q)
    );

    uecs_sticky u_crc (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_set  (i_evt.checksum_error),
        .i_clr  (wr_tes && !i_mem.wdata[TES_CHECKSUM_ERROR]), // see RULE_13
        .o_q    (crc_q)
    );

    // read-only to firmware; the engine clears it on a SETUP token or while an IN token is current
    uecs_sticky u_nak (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_set  (i_evt.nak_sent),                             // see RULE_12
        .i_clr  (i_evt.setup_token || i_lvl.in_token),
        .o_q    (nak_q)
    );

    uecs_sticky u_zlen (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_set  (i_evt.zero_length),
        .i_clr  (fifo_rd || i_evt.setup_token),               // see RULE_21
        .o_q    (zlen_q)
    );

    uecs_sticky u_setup (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_set  (i_evt.setup_command),
        .i_clr  (wr_fcs && !i_mem.wdata[FCS_SETUP_COMMAND]),
        .o_q    (setup_q)
    );

    // masked nak event
    logic nak_irq_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            nak_irq_ff <= 1'b0;
        end else begin
            nak_irq_ff <= i_evt.nak_sent && !nak_mask_ff;     // see RULE_15
        end
    end

    assign o_nak_irq = nak_irq_ff;

    ////////////////////////////////////////////////////////////////////////////
    // fifo command fields
    logic [1:0] sel_ff;
    logic       req_ff;
    logic       dir_ff;
    logic       clr_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            req_ff <= 1'b0;
            dir_ff <= 1'b0;
            clr_ff <= 1'b0;
            sel_ff <= SEL_FIFO0;
        end else if (wr_fcs) begin
            req_ff <= i_mem.wdata[FCS_REQUEST];               // see RULE_19
            dir_ff <= i_mem.wdata[FCS_DIRECTION];             // see RULE_20
            clr_ff <= i_mem.wdata[FCS_CLEAR];
            sel_ff <= {i_mem.wdata[FCS_PIPE_SELECT_HIGH], i_mem.wdata[FCS_PIPE_SELECT_LOW]};
        end
    end

    assign o_fifo_request = req_ff;
    assign o_fifo_write   = dir_ff;
    assign o_fifo_clear   = clr_ff;
    assign o_fifo_select  = sel_ff;

    // code 11 selects nothing
    always_comb begin
        o_fifo_onehot = 3'h0;
        unique case (sel_ff)
            SEL_FIFO0: o_fifo_onehot = 3'h1;                  // see RULE_18
            SEL_FIFO1: o_fifo_onehot = 3'h2;
            SEL_FIFO2: o_fifo_onehot = 3'h4;
            default:   o_fifo_onehot = 3'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux, registered so data outputs come from flip-flops
    logic [7:0] tes_word;
    logic [7:0] fcs_word;
    logic [7:0] nxt_rdata;
    logic       nxt_hit;
    logic [7:0] rdata_ff;
    logic       hit_ff;

    always_comb begin
        tes_word = 8'h00;
        tes_word[TES_NAK_INT_MASK]     = nak_mask_ff;         // see RULE_16
        tes_word[TES_END_OF_TRANSFER]  = i_lvl.end_of_transfer_flag; // see RULE_14
        tes_word[TES_CHECKSUM_ERROR]   = crc_q;
        tes_word[TES_NAK_SENT]         = nak_q;
        tes_word[TES_IN_TOKEN]         = i_lvl.in_token;      // see RULE_11
        tes_word[TES_OUT_RECEIVED]     = out_q;
        tes_word[TES_EP0_FIFO_ERROR]   = ep0_err_q;
        tes_word[TES_ADDR_UPDATE_MODE] = mode_ff;
    end

    always_comb begin
        fcs_word = 8'h00;
        fcs_word[FCS_ZERO_LENGTH]      = zlen_q;              // see RULE_17
        fcs_word[FCS_READY]            = i_lvl.fifo_ready;
        fcs_word[FCS_SETUP_COMMAND]    = setup_q;
        fcs_word[FCS_PIPE_SELECT_HIGH] = sel_ff[1];
        fcs_word[FCS_PIPE_SELECT_LOW]  = sel_ff[0];
        fcs_word[FCS_CLEAR]            = clr_ff;
        fcs_word[FCS_DIRECTION]        = dir_ff;
        fcs_word[FCS_REQUEST]          = req_ff;
    end

    always_comb begin
        nxt_rdata = 8'h00;
        nxt_hit   = 1'b1;
        unique case (i_mem.addr)
            ADDR_PIPE_DIRECTION_TOGGLE: nxt_rdata = {5'h00, pdt_ff}; // see RULE_22
            ADDR_DEVICE_ADDRESS:        nxt_rdata = adr_reg_ff;
            ADDR_ENDPOINT_HALT_FLAGS:   nxt_rdata = {5'h00, hlt_ff};
            ADDR_TOKEN_ERROR_STATUS:    nxt_rdata = tes_word;
            ADDR_FIFO_COMMAND_STATUS:   nxt_rdata = fcs_word;
            ADDR_ENDPOINT_ENABLE:       nxt_rdata = {5'h00, een_ff};
            default:                    nxt_hit   = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rdata_ff <= 8'h00;
            hit_ff   <= 1'b0;
        end else if (i_mem.rd) begin
            rdata_ff <= nxt_rdata;
            hit_ff   <= nxt_hit;
        end else begin
            hit_ff   <= 1'b0;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_hit   = hit_ff;

endmodule : uecs_top
`default_nettype wire
